// File: hw/stream_tx_map.vh
`ifndef STREAM_TX_MAP_VH
`define STREAM_TX_MAP_VH

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define TX_WORD_NATIVE 64
`define TX_WORD_LEGACY 40
`define TX_LANES 2
`define TX_FIFO_DEPTH 16
`define TX_FIFO_AW 4
`define TX_BURST_MAX 8
`define TX_FIFO_HEADROOM 3

// ----------------------------------------
// Control word type field (top 8 bits of a lane word) and sync bit position
// ----------------------------------------
`define CW_TYPE_W 8
`define CW_IDLE_NONUSER 8'h01
`define CW_SOB 8'h02
`define CW_EOB 8'h03
`define CW_SYNC_BIT 4

// ----------------------------------------
// Clock generator
// ----------------------------------------
`define CLK_VAR_LEGACY 2'h0
`define CLK_VAR_USER_ONLY 2'h1
`define CLK_VAR_NONE 2'h2
`define USER_DIV 4'h2
`define CORE_DIV 4'h1

`endif

// File: hw/ecc_fifo.v
`timescale 1ns/100ps
`include "stream_tx_map.vh"

module ecc_fifo #(
    parameter W = 128,
    parameter DEPTH = `TX_FIFO_DEPTH,
    parameter AW = `TX_FIFO_AW
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_reset,
    // Write side
    input wire i_push,
    input wire [W-1:0] i_wdata,
    input wire [1:0] i_flip,
    // Read side
    input wire i_pop,
    output wire [W-1:0] o_rdata,
    output wire o_empty,
    output wire o_fatal,
    output wire [AW:0] o_count
);
    // Each entry holds two parity-protected copies; a bad copy is replaced by
    // the good one, so any single-bit upset is corrected.
    reg [W:0] copy_a [0:DEPTH-1];
    reg [W:0] copy_b [0:DEPTH-1];
    reg [AW-1:0] wptr_ff;
    reg [AW-1:0] rptr_ff;
    reg [AW:0] count_ff;
    wire [W:0] ra;
    wire [W:0] rb;
    wire a_ok;
    wire b_ok;

    always @(posedge i_mclk) begin
        if (i_push) begin
            copy_a[wptr_ff] <= {^i_wdata, i_wdata ^ {{(W-1){1'b0}}, i_flip[0]}};
            copy_b[wptr_ff] <= {^i_wdata, i_wdata ^ {{(W-1){1'b0}}, i_flip[1]}};
        end
    end

    always @(posedge i_mclk) begin
        if (i_reset) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (i_push)
                wptr_ff <= wptr_ff + {{(AW-1){1'b0}}, 1'b1};
            if (i_pop)
                rptr_ff <= rptr_ff + {{(AW-1){1'b0}}, 1'b1};
            count_ff <= count_ff + {{AW{1'b0}}, i_push} - {{AW{1'b0}}, i_pop};
        end
    end

    assign ra = copy_a[rptr_ff];
    assign rb = copy_b[rptr_ff];
    assign a_ok = (^ra[W-1:0]) == ra[W];
    assign b_ok = (^rb[W-1:0]) == rb[W];
    assign o_rdata = a_ok ? ra[W-1:0] : rb[W-1:0];
    assign o_fatal = i_pop & ~a_ok & ~b_ok;
    assign o_empty = (count_ff == {(AW+1){1'b0}});
    assign o_count = count_ff;
endmodule

// File: hw/stream_source_tx_framer.v
`timescale 1ns/100ps
`include "stream_tx_map.vh"
// Operation
// - Burst control words mark burst start and end
// - Idle control words go on every lane
// - FIFO absorbs bursty transceiver read requests
// - FIFO carries user data to core timing
// - State machine maps framing to transceiver handshake
// - Non-user idles fill gaps without user data
// - ECC corrects data, flags uncorrectable as fatal
// - Word width 64 native, 40 legacy
// - Start, sync and end wrap each burst
// - User reset held until PLL lock
// - Clock generator active only in standard mode
// - Legacy variant divides both clocks at fixed ratios
// - User-only variant: core clock follows transceiver clock in standard mode, held low otherwise
// - No generator: transceiver clock drives core clock

module stream_source_tx_framer #(
    parameter LEGACY_PHY = 0,
    parameter LANES = `TX_LANES,
    parameter DEPTH = `TX_FIFO_DEPTH,
    parameter AW = `TX_FIFO_AW,
    parameter BURST_MAX = `TX_BURST_MAX,
    parameter [1:0] CLK_VARIANT = `CLK_VAR_LEGACY,
    parameter WORD_W = LEGACY_PHY ? `TX_WORD_LEGACY : `TX_WORD_NATIVE
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_reset,
    // Clocking mode and clock generator
    input wire i_std_clk_mode,
    input wire i_pll_locked,
    input wire i_tx_clkout,
    output reg o_user_clk,
    output reg o_core_clk,
    output reg o_user_reset,
    // User stream
    input wire i_valid,
    input wire [LANES*WORD_W-1:0] i_data,
    input wire [1:0] i_ecc_flip,
    output reg o_ready,
    // Transceiver transmit side
    input wire i_tx_ready,
    output reg [LANES*WORD_W-1:0] o_tx_data,
    output reg [LANES-1:0] o_tx_ctrl,
    output reg o_tx_valid,
    // Status
    output reg o_ecc_fatal
);
    localparam DW = LANES * WORD_W;
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_DATA = 2'h1;
    localparam [1:0] S_EOB = 2'h2;
    localparam [7:0] BURST_LAST = BURST_MAX - 1;
    localparam [AW:0] READY_LIMIT = DEPTH - `TX_FIFO_HEADROOM;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [7:0] bcnt_ff;
    reg [7:0] nxt_bcnt;
    reg [3:0] udiv_ff;
    reg [3:0] cdiv_ff;
    reg [DW-1:0] nxt_data;
    reg [LANES-1:0] nxt_ctrl;
    reg pop;
    reg [7:0] cw_type;
    reg cw_sync;
    wire [DW-1:0] fifo_data;
    wire fifo_empty;
    wire fifo_fatal;
    wire [AW:0] fifo_count;
    wire push;
    wire [DW-1:0] cw_all;

    // ----------------------------------------
    // Rate adaptation buffer
    // ----------------------------------------
    assign push = i_valid & o_ready;

    ecc_fifo #(
        .W(DW),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_push(push),
        .i_wdata(i_data),
        .i_flip(i_ecc_flip),
        .i_pop(pop),
        .o_rdata(fifo_data),
        .o_empty(fifo_empty),
        .o_fatal(fifo_fatal),
        .o_count(fifo_count)
    );

    // ----------------------------------------
    // Control word replicated on all lanes
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            assign cw_all[g*WORD_W +: WORD_W] = {cw_type,
                {(WORD_W-`CW_TYPE_W-`CW_SYNC_BIT-1){1'b0}}, cw_sync,
                {`CW_SYNC_BIT{1'b0}}};
        end
    endgenerate

    // ----------------------------------------
    // Framing state machine
    // ----------------------------------------
    // Control word type depends on state and the FIFO empty flag only, so cw_all never feeds back on itself
    always @* begin
        cw_type = `CW_IDLE_NONUSER;
        cw_sync = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (!fifo_empty) begin
                    cw_type = `CW_SOB;
                    cw_sync = 1'b1;
                end
            end
            S_DATA: begin
                if (fifo_empty)
                    cw_type = `CW_EOB;
            end
            S_EOB: begin
                cw_type = `CW_EOB;
            end
            default: begin
                cw_type = `CW_IDLE_NONUSER;
            end
        endcase
    end

    // The transceiver pulls words in bursts; nothing advances unless it is ready.
    always @* begin
        nxt_state = state_ff;
        nxt_bcnt = bcnt_ff;
        pop = 1'b0;
        nxt_data = cw_all;
        nxt_ctrl = {LANES{1'b1}};
        if (i_tx_ready) begin
            case (state_ff)
                S_IDLE: begin
                    if (!fifo_empty) begin
                        nxt_bcnt = 8'h00;
                        nxt_state = S_DATA;
                    end
                end
                S_DATA: begin
                    if (!fifo_empty) begin
                        pop = 1'b1;
                        nxt_data = fifo_data;
                        nxt_ctrl = {LANES{1'b0}};
                        nxt_bcnt = bcnt_ff + 8'h01;
                        if (bcnt_ff == BURST_LAST)
                            nxt_state = S_EOB;
                    end else begin
                        nxt_state = S_IDLE;
                    end
                end
                S_EOB: begin
                    nxt_state = S_IDLE;
                end
                default: begin
                    nxt_state = S_IDLE;
                end
            endcase
        end
    end

    always @(posedge i_mclk) begin
        if (i_reset) begin
            state_ff <= S_IDLE;
            bcnt_ff <= 8'h00;
            o_tx_data <= {DW{1'b0}};
            o_tx_ctrl <= {LANES{1'b0}};
            o_tx_valid <= 1'b0;
            o_ready <= 1'b0;
            o_ecc_fatal <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bcnt_ff <= nxt_bcnt;
            if (i_tx_ready) begin
                o_tx_data <= nxt_data;
                o_tx_ctrl <= nxt_ctrl;
            end
            o_tx_valid <= i_tx_ready;
            // Headroom covers the one-cycle lag of the registered ready
            o_ready <= (fifo_count <= READY_LIMIT);
            if (fifo_fatal)
                o_ecc_fatal <= 1'b1;
        end
    end

    // ----------------------------------------
    // Clock generator and reset sequencing
    // ----------------------------------------
    // Clocks are modelled as divided levels; a real chip uses a PLL here.
    always @(posedge i_mclk) begin
        if (i_reset) begin
            udiv_ff <= 4'h0;
            cdiv_ff <= 4'h0;
            o_user_clk <= 1'b0;
            o_core_clk <= 1'b0;
            o_user_reset <= 1'b1;
        end else if (!i_std_clk_mode) begin
            o_user_clk <= 1'b0;
            o_core_clk <= (CLK_VARIANT == `CLK_VAR_NONE) ? i_tx_clkout : 1'b0;
            o_user_reset <= 1'b1;
        end else begin
            o_user_reset <= ~i_pll_locked;
            if (i_pll_locked) begin
                udiv_ff <= (udiv_ff == `USER_DIV - 4'h1) ? 4'h0 : udiv_ff + 4'h1;
                if (udiv_ff == `USER_DIV - 4'h1)
                    o_user_clk <= ~o_user_clk;
            end
            if (CLK_VARIANT == `CLK_VAR_LEGACY) begin
                cdiv_ff <= (cdiv_ff == `CORE_DIV - 4'h1) ? 4'h0 : cdiv_ff + 4'h1;
                if (i_pll_locked && cdiv_ff == `CORE_DIV - 4'h1)
                    o_core_clk <= ~o_core_clk;
            end else begin
                o_core_clk <= i_tx_clkout;
            end
        end
    end
endmodule

// File: dv/stream_source_tx_framer_asserts.sv
`timescale 1ns/100ps
module stream_source_tx_framer_asserts #(
    parameter LANES = 2,
    parameter WORD_W = 64
) (
    input wire i_mclk,
    input wire i_reset,
    input wire i_std_clk_mode,
    input wire i_pll_locked,
    input wire i_tx_ready,
    input wire o_user_clk,
    input wire o_user_reset,
    input wire o_ready,
    input wire [LANES*WORD_W-1:0] o_tx_data,
    input wire [LANES-1:0] o_tx_ctrl,
    input wire o_tx_valid,
    input wire o_ecc_fatal
);
// Type field of lanes 0 and 1; two lanes at least are assumed
wire [7:0] t0 = o_tx_data[WORD_W-1 -: 8];
wire [7:0] t1 = o_tx_data[2*WORD_W-1 -: 8];
default clocking @(posedge i_mclk); endclocking
default disable iff (i_reset);
property p_load; i_tx_ready |=> o_tx_valid; endproperty
a_load: assert property (p_load) else $error("no word after read");
property p_hold; !i_tx_ready |=> $stable(o_tx_data) && !o_tx_valid; endproperty
a_hold: assert property (p_hold) else $error("word moved without read");
property p_lanes; |o_tx_ctrl |-> &o_tx_ctrl; endproperty
a_lanes: assert property (p_lanes) else $error("control word on part of lanes");
property p_same; o_tx_ctrl[0] |-> t0 == t1; endproperty
a_same: assert property (p_same) else $error("lanes disagree on type");
property p_type; o_tx_ctrl[0] |-> t0 inside {8'h01, 8'h02, 8'h03}; endproperty
a_type: assert property (p_type) else $error("unknown control type");
property p_ureset; !i_pll_locked ##1 !i_pll_locked |-> o_user_reset; endproperty
a_ureset: assert property (p_ureset) else $error("user reset left before lock");
property p_adv; !i_std_clk_mode ##1 !i_std_clk_mode |-> !o_user_clk && o_user_reset; endproperty
a_adv: assert property (p_adv) else $error("generator live in advanced mode");
property p_fatal; o_ecc_fatal |=> o_ecc_fatal; endproperty
a_fatal: assert property (p_fatal) else $error("fatal flag dropped");
c_eob: cover property (o_tx_valid && o_tx_ctrl[0] && t0 == 8'h03);
c_full: cover property ($fell(o_ready));
c_fatal: cover property ($rose(o_ecc_fatal));
endmodule

bind stream_source_tx_framer stream_source_tx_framer_asserts #(.LANES(LANES), .WORD_W(WORD_W))
    u_stream_source_tx_framer_asserts (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_std_clk_mode(i_std_clk_mode), .i_pll_locked(i_pll_locked), .i_tx_ready(i_tx_ready),
    .o_user_clk(o_user_clk), .o_user_reset(o_user_reset), .o_ready(o_ready),
    .o_tx_data(o_tx_data), .o_tx_ctrl(o_tx_ctrl), .o_tx_valid(o_tx_valid),
    .o_ecc_fatal(o_ecc_fatal));

// File: dv/tx_sink_model.sv
`timescale 1ns/100ps
module tx_sink_model #(
    parameter DW = 128
) (
    input wire i_mclk,
    input wire i_reset,
    input wire [1:0] i_mode,
    input wire i_tx_valid,
    input wire [DW-1:0] i_tx_data,
    input wire [1:0] i_tx_ctrl,
    output reg o_tx_ready,
    output reg o_got,
    output reg [DW-1:0] o_word
);
reg [1:0] cnt_ff;
always @(posedge i_mclk) begin
    cnt_ff <= i_reset ? 2'h0 : cnt_ff + 2'h1;
    // Slow mode stalls one cycle in four, mode 2 stops reading
    o_tx_ready <= !i_reset && i_mode != 2'h2 && !(i_mode == 2'h1 && cnt_ff == 2'h3);
    // Control words, non-user idles among them, never reach the user
    o_got <= i_tx_valid && i_tx_ctrl == 2'h0;
    o_word <= i_tx_data;
end
endmodule

// File: dv/stream_source_tx_framer_tb.sv
`timescale 1ns/100ps
module stream_source_tx_framer_tb;
reg i_mclk = 0, i_reset = 1, i_std_clk_mode = 1, i_pll_locked = 0, i_tx_clkout = 0;
reg i_valid = 0;
reg [127:0] i_data = 128'h0;
reg [1:0] i_ecc_flip = 2'h0, mode = 2'h0;
wire o_user_clk, o_core_clk, o_user_reset, o_ready, o_tx_valid, o_ecc_fatal, i_tx_ready, got;
wire [127:0] o_tx_data, word;
wire [1:0] o_tx_ctrl;
int fails = 0, check_count = 0, cyc = 0, n, i;
bit chk_on = 1, acc, ucl;
logic [127:0] exp_q[$];
logic [131:0] rows [0:11];
stream_source_tx_framer u_stream_source_tx_framer (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_std_clk_mode(i_std_clk_mode), .i_pll_locked(i_pll_locked), .i_tx_clkout(i_tx_clkout),
    .o_user_clk(o_user_clk), .o_core_clk(o_core_clk), .o_user_reset(o_user_reset),
    .i_valid(i_valid), .i_data(i_data), .i_ecc_flip(i_ecc_flip), .o_ready(o_ready),
    .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data), .o_tx_ctrl(o_tx_ctrl),
    .o_tx_valid(o_tx_valid), .o_ecc_fatal(o_ecc_fatal));
tx_sink_model u_tx_sink_model (.i_mclk(i_mclk), .i_reset(i_reset), .i_mode(mode),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_ctrl(o_tx_ctrl),
    .o_tx_ready(i_tx_ready), .o_got(got), .o_word(word));
// Second copy without a clock generator: core clock comes from the transceiver
wire core_clk_none;
stream_source_tx_framer #(.CLK_VARIANT(2'h2)) u_stream_source_tx_framer_none (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_std_clk_mode(i_std_clk_mode), .i_pll_locked(i_pll_locked),
    .i_tx_clkout(i_tx_clkout), .o_user_clk(), .o_core_clk(core_clk_none), .o_user_reset(),
    .i_valid(1'b0), .i_data(128'h0), .i_ecc_flip(2'h0), .o_ready(), .i_tx_ready(i_tx_ready),
    .o_tx_data(), .o_tx_ctrl(), .o_tx_valid(), .o_ecc_fatal());
task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
        fails++;
        $display("ERROR %0t %s", $time, m);
    end
endtask
task end_of_test;
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
// Called at a rising edge; returns at the edge that takes the word
task push(input logic [127:0] d, input logic [1:0] f);
    i_valid <= 1'b1;
    i_data <= d;
    i_ecc_flip <= f;
    @(negedge i_mclk);
    while (!o_ready) @(negedge i_mclk);
    @(posedge i_mclk);
    exp_q.push_back(d);
endtask
task drain;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
        @(negedge i_mclk);
        n++;
    end
    @(posedge i_mclk);
endtask
initial forever #20 i_mclk = ~i_mclk;
always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    i_tx_clkout <= ~i_tx_clkout;
    if (got && chk_on) chk(exp_q.size() > 0 && word === exp_q.pop_front(), "word lost");
    if (cyc == 5000) begin
        chk(0, "timeout");
        end_of_test;
    end
end
initial begin
    for (i = 0; i < 12; i++)
        rows[i] = {2'(i % 2), 2'(i == 5 ? 1 : (i == 6 ? 2 : 0)), {4{32'hC0DE0000 + 32'(i)}}};
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (4) @(negedge i_mclk);
    chk(o_user_reset === 1'b1, "user reset before lock");
    @(posedge i_mclk);
    i_pll_locked <= 1'b1;
    n = 0;
    while (o_user_reset !== 1'b0 && n < 20) begin
        @(negedge i_mclk);
        n++;
    end
    chk(o_user_reset === 1'b0, "user reset stuck");
    acc = o_core_clk;
    ucl = o_user_clk;
    @(negedge i_mclk);
    chk(o_core_clk === !acc, "core clock not divided");
    chk(core_clk_none === !i_tx_clkout, "core clock off transceiver rate");
    @(negedge i_mclk);
    chk(o_user_clk === !ucl, "user clock not divided");
    @(posedge i_mclk);
    // Twelve words cross the burst limit of eight; flips 1 and 2 get corrected
    for (i = 0; i < 12; i++) begin
        mode <= rows[i][131:130];
        push(rows[i][127:0], rows[i][129:128]);
    end
    i_valid <= 1'b0;
    mode <= 2'h0;
    drain;
    chk(exp_q.size() == 0, "burst data lost");
    repeat (4) @(negedge i_mclk);
    chk(o_tx_ctrl === 2'h3 && o_tx_data[127:120] === 8'h01 && o_tx_data[63:56] === 8'h01,
        "no idle when empty");
    @(posedge i_mclk);
    mode <= 2'h2;
    i_valid <= 1'b1;
    i_ecc_flip <= 2'h0;
    n = 0;
    repeat (24) begin
        @(negedge i_mclk);
        acc = o_ready;
        @(posedge i_mclk);
        if (acc) begin
            exp_q.push_back(i_data);
            n++;
            i_data <= i_data + 128'h1;
        end
    end
    i_valid <= 1'b0;
    @(negedge i_mclk);
    chk(n > 0 && n <= 16 && o_ready === 1'b0, "no backpressure");
    @(posedge i_mclk);
    mode <= 2'h0;
    drain;
    chk(exp_q.size() == 0, "stalled data lost");
    chk(o_ecc_fatal === 1'b0, "single error flagged fatal");
    chk_on = 0;
    push(128'hDEAD0000BEEF0000DEAD0000BEEF0000, 2'h3);
    exp_q.delete();
    i_valid <= 1'b0;
    drain;
    repeat (6) @(negedge i_mclk);
    chk(o_ecc_fatal === 1'b1, "double error unflagged");
    @(posedge i_mclk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    i_std_clk_mode <= 1'b0;
    repeat (4) @(negedge i_mclk);
    chk(o_ecc_fatal === 1'b0, "fatal kept over reset");
    chk(o_user_reset === 1'b1 && o_user_clk === 1'b0, "generator in advanced mode");
    chk(o_core_clk === 1'b0, "core clock in advanced mode");
    chk(core_clk_none === !i_tx_clkout, "core clock not from transceiver");
    chk(o_ready === 1'b1 && o_tx_ctrl === 2'h3, "no idle after reset");
    end_of_test;
end
endmodule
